/* pkg/dgcc_pkg.sv */
// Purpose: Shared constants and types for the converter configuration bank
// Assumes: 16-bit registers, 8-bit register index from the serial decoder
// Notes: All registers reset to zero
package dgcc_pkg;
  // Register indices
  localparam logic [7:0] ADDR_CH2_LOWER = 8'h02;
  localparam logic [7:0] ADDR_CH2_GAIN = 8'h03;
  localparam logic [7:0] ADDR_CH0_GAIN = 8'h0f;
  localparam logic [7:0] ADDR_CH1_UPPER = 8'h13;
  localparam logic [7:0] ADDR_CH1_GAIN_CMP = 8'h15;
  localparam logic [7:0] ADDR_CH1_CMP_MODE = 8'h17;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  // Writable bit masks; everything else is don't-care and reads zero
  localparam logic [15:0] MASK_BOUND = 16'hfff0;
  localparam logic [15:0] MASK_GAIN = 16'h1c00;
  localparam logic [15:0] MASK_GAIN_CMP = 16'h1c1f;
  localparam logic [15:0] MASK_CMP_MODE = 16'h0c00;
  // Field positions
  localparam int BOUND_MSB = 15;
  localparam int BOUND_LSB = 6; // 10-bit code sits left-aligned; bits 5:4 carry no code
  localparam int GAIN_MSB = 12;
  localparam int GAIN_LSB = 10;
  localparam int MODE_MSB = 11;
  localparam int MODE_LSB = 10;
  localparam int BIT_CMP_EN = 0;
  localparam int BIT_CMP_INV = 1;
  localparam int BIT_CMP_HIZ_DIS = 2;
  localparam int BIT_CMP_PIN = 3;
  localparam int BIT_CMP_OD = 4;
  // Voltage channel reference and gain codes
  localparam logic [2:0] REF_GAIN_1X_SUPPLY = 3'h1;
  localparam logic [2:0] REF_GAIN_4X_INT = 3'h5;
  // Current channel range codes
  localparam logic [2:0] CUR_GAIN_2_3 = 3'h0;
  localparam logic [2:0] CUR_GAIN_1_2 = 3'h1;

  typedef enum logic [1:0] {
    CMP_PLAIN = 2'b00,
    CMP_HYST = 2'b01,
    CMP_WINDOW = 2'b10,
    CMP_INVALID = 2'b11
  } dgcc_mode_t;

  // One register access from the serial decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } dgcc_req_t;
endpackage : dgcc_pkg

/* rtl/dgcc_regs.sv */
// Purpose: Configuration register bank with channel 1 comparator output logic
// Assumes: Requests come one per cycle from the serial decoder, in clock domain
// Notes: Analog comparisons arrive as synchronous levels; read data lags a cycle
// How it works
// R01: Channel 2 lower bound: 10-bit code, bits 15:6
// R02: Voltage gain field 001..101 valid, others invalid
// R03: Current gain 000 is 2/3, 001 is 1/2
// R04: Bit 0 enables comparator mode on channel 1
// R05: Bit 1 inverts the comparator result
// R06: Bit 3 routes result onto channel 1 pin
// R07: Bit 4 open-drain, only with mode and pin
// R08: Bit 2 gives feedback input finite impedance
// R09: Mode field: plain, hysteresis, window, invalid
// R10: Registers at 02h,03h,0Fh,15h,17h reset to zero
// R11: Channel 1 upper bound at 13h, left-aligned
// R12: Don't-care bits ignore writes, read zero
module dgcc_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register access from the serial port
  input wire dgcc_pkg::dgcc_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  // Analog comparator levels for channel 1
  input wire logic cmp_above_code,
  input wire logic cmp_above_upper,
  input wire logic cmp_above_lower,
  // Channel 1 lower bound code, held elsewhere
  input wire logic [9:0] ch1_lower_code,
  // Decoded configuration
  output logic [9:0] ch2_lower_code,
  output logic [9:0] ch1_upper_code,
  output logic [2:0] ch0_ref_gain,
  output logic ch0_gain_valid,
  output logic [2:0] ch1_ref_gain,
  output logic ch1_gain_valid,
  output logic [2:0] current_range_field,
  output logic current_range_valid,
  output logic cmp_mode_enable,
  output logic cmp_feedback_hiz_disable,
  output logic [1:0] cmp_threshold_mode,
  output logic cmp_mode_valid,
  // Comparator result and channel 1 pin
  output logic cmp_result,
  output logic ch1_output_pin_o,
  output logic ch1_output_pin_oe
);
  logic [15:0] ch2_lower_ff, ch2_gain_ff, ch0_gain_ff, ch1_upper_ff, ch1_cmp_ff, ch1_mode_ff;
  logic [15:0] nxt_ch2_lower, nxt_ch2_gain, nxt_ch0_gain, nxt_ch1_upper, nxt_ch1_cmp, nxt_ch1_mode;
  logic [15:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic hyst_ff, nxt_hyst;
  logic result_ff, nxt_result;
  logic pin_o_ff, nxt_pin_o;
  logic pin_oe_ff, nxt_pin_oe;
  logic raw;
  dgcc_pkg::dgcc_mode_t mode;

  // Register writes and reads; masking drops the don't-care bits
  always_comb begin
    nxt_ch2_lower = ch2_lower_ff;
    nxt_ch2_gain = ch2_gain_ff;
    nxt_ch0_gain = ch0_gain_ff;
    nxt_ch1_upper = ch1_upper_ff;
    nxt_ch1_cmp = ch1_cmp_ff;
    nxt_ch1_mode = ch1_mode_ff;
    nxt_rvalid = req.rd;
    nxt_rdata = rdata_ff;
    if (req.wr) begin
      case (req.addr)
        dgcc_pkg::ADDR_CH2_LOWER: nxt_ch2_lower = req.wdata & dgcc_pkg::MASK_BOUND; // R01 R12
        dgcc_pkg::ADDR_CH2_GAIN: nxt_ch2_gain = req.wdata & dgcc_pkg::MASK_GAIN; // R12
        dgcc_pkg::ADDR_CH0_GAIN: nxt_ch0_gain = req.wdata & dgcc_pkg::MASK_GAIN; // R12
        dgcc_pkg::ADDR_CH1_UPPER: nxt_ch1_upper = req.wdata & dgcc_pkg::MASK_BOUND; // R11
        dgcc_pkg::ADDR_CH1_GAIN_CMP: nxt_ch1_cmp = req.wdata & dgcc_pkg::MASK_GAIN_CMP; // R12
        dgcc_pkg::ADDR_CH1_CMP_MODE: nxt_ch1_mode = req.wdata & dgcc_pkg::MASK_CMP_MODE; // R12
        default: ;
      endcase
    end
    // Reads see the value before a same-cycle write
    if (req.rd) begin
      case (req.addr)
        dgcc_pkg::ADDR_CH2_LOWER: nxt_rdata = ch2_lower_ff; // R10
        dgcc_pkg::ADDR_CH2_GAIN: nxt_rdata = ch2_gain_ff;
        dgcc_pkg::ADDR_CH0_GAIN: nxt_rdata = ch0_gain_ff;
        dgcc_pkg::ADDR_CH1_UPPER: nxt_rdata = ch1_upper_ff;
        dgcc_pkg::ADDR_CH1_GAIN_CMP: nxt_rdata = ch1_cmp_ff;
        dgcc_pkg::ADDR_CH1_CMP_MODE: nxt_rdata = ch1_mode_ff;
        default: nxt_rdata = 16'h0000; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ch2_lower_ff <= dgcc_pkg::RESET_VALUE; // R10
      ch2_gain_ff <= dgcc_pkg::RESET_VALUE;
      ch0_gain_ff <= dgcc_pkg::RESET_VALUE;
      ch1_upper_ff <= dgcc_pkg::RESET_VALUE;
      ch1_cmp_ff <= dgcc_pkg::RESET_VALUE;
      ch1_mode_ff <= dgcc_pkg::RESET_VALUE;
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      ch2_lower_ff <= nxt_ch2_lower;
      ch2_gain_ff <= nxt_ch2_gain;
      ch0_gain_ff <= nxt_ch0_gain;
      ch1_upper_ff <= nxt_ch1_upper;
      ch1_cmp_ff <= nxt_ch1_cmp;
      ch1_mode_ff <= nxt_ch1_mode;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Field decode straight off the register flops
  assign ch2_lower_code = ch2_lower_ff[dgcc_pkg::BOUND_MSB:dgcc_pkg::BOUND_LSB]; // R01
  assign ch1_upper_code = ch1_upper_ff[dgcc_pkg::BOUND_MSB:dgcc_pkg::BOUND_LSB]; // R11
  assign ch0_ref_gain = ch0_gain_ff[dgcc_pkg::GAIN_MSB:dgcc_pkg::GAIN_LSB];
  assign ch1_ref_gain = ch1_cmp_ff[dgcc_pkg::GAIN_MSB:dgcc_pkg::GAIN_LSB];
  assign current_range_field = ch2_gain_ff[dgcc_pkg::GAIN_MSB:dgcc_pkg::GAIN_LSB];
  assign ch0_gain_valid = (ch0_ref_gain >= dgcc_pkg::REF_GAIN_1X_SUPPLY) &&
                          (ch0_ref_gain <= dgcc_pkg::REF_GAIN_4X_INT); // R02
  assign ch1_gain_valid = (ch1_ref_gain >= dgcc_pkg::REF_GAIN_1X_SUPPLY) &&
                          (ch1_ref_gain <= dgcc_pkg::REF_GAIN_4X_INT); // R02
  assign current_range_valid = (current_range_field == dgcc_pkg::CUR_GAIN_2_3) ||
                               (current_range_field == dgcc_pkg::CUR_GAIN_1_2); // R03
  assign cmp_mode_enable = ch1_cmp_ff[dgcc_pkg::BIT_CMP_EN]; // R04
  assign cmp_feedback_hiz_disable = ch1_cmp_ff[dgcc_pkg::BIT_CMP_HIZ_DIS]; // R08
  assign cmp_threshold_mode = ch1_mode_ff[dgcc_pkg::MODE_MSB:dgcc_pkg::MODE_LSB];
  assign cmp_mode_valid = (cmp_threshold_mode != dgcc_pkg::CMP_INVALID); // R09
  assign mode = dgcc_pkg::dgcc_mode_t'(cmp_threshold_mode);
  assign rdata = rdata_ff;
  assign rvalid = rvalid_ff;

  // Comparator: threshold mode, inversion, pin drive. Invalid mode holds raw low
  // so a bad setting never toggles the pin unexpectedly.
  always_comb begin
    nxt_hyst = hyst_ff;
    raw = 1'b0;
    case (mode)
      dgcc_pkg::CMP_PLAIN: raw = cmp_above_code; // R09
      dgcc_pkg::CMP_HYST: begin // R09
        if (cmp_above_upper) begin
          nxt_hyst = 1'b1;
        end else if (!cmp_above_lower) begin
          nxt_hyst = 1'b0;
        end
        raw = nxt_hyst;
      end
      dgcc_pkg::CMP_WINDOW: raw = cmp_above_lower && !cmp_above_upper; // R09
      default: raw = 1'b0;
    endcase
    if (!cmp_mode_enable) begin
      nxt_hyst = 1'b0;
    end
    nxt_result = cmp_mode_enable && (raw ^ ch1_cmp_ff[dgcc_pkg::BIT_CMP_INV]); // R04 R05
    nxt_pin_o = 1'b0;
    nxt_pin_oe = 1'b0;
    if (cmp_mode_enable && ch1_cmp_ff[dgcc_pkg::BIT_CMP_PIN]) begin // R06
      if (ch1_cmp_ff[dgcc_pkg::BIT_CMP_OD]) begin
        nxt_pin_oe = !nxt_result; // R07
      end else begin
        nxt_pin_o = nxt_result;
        nxt_pin_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hyst_ff <= 1'b0;
      result_ff <= 1'b0;
      pin_o_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      hyst_ff <= nxt_hyst;
      result_ff <= nxt_result;
      pin_o_ff <= nxt_pin_o;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign cmp_result = result_ff;
  assign ch1_output_pin_o = pin_o_ff;
  assign ch1_output_pin_oe = pin_oe_ff;

  a_lower_low_zero: assert property (@(posedge clock) disable iff (!reset_n) // R01
    ch2_lower_ff[3:0] == 4'h0) else $error("lower bound low bits not zero");
  a_gain_valid_dec: assert property (@(posedge clock) disable iff (!reset_n) // R02
    ch0_gain_valid == (ch0_ref_gain inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5})) else $error("ch0 gain decode wrong");
  a_current_range_dec: assert property (@(posedge clock) disable iff (!reset_n) // R03
    current_range_valid == (current_range_field[2:1] == 2'b00)) else $error("current range decode wrong");
  a_disabled_quiet: assert property (@(posedge clock) disable iff (!reset_n) // R04
    $past(!cmp_mode_enable) |-> !cmp_result && !ch1_output_pin_oe) else $error("comparator active while off");
  a_plain_invert: assert property (@(posedge clock) disable iff (!reset_n) // R05
    cmp_mode_enable && mode == dgcc_pkg::CMP_PLAIN |=>
    cmp_result == ($past(cmp_above_code) ^ $past(ch1_cmp_ff[1]))) else $error("plain result or inversion wrong");
  a_pin_internal: assert property (@(posedge clock) disable iff (!reset_n) // R06
    !ch1_cmp_ff[3] |=> !ch1_output_pin_oe) else $error("pin driven while internal only");
  // Push-pull drive must follow the registered result on both levels
  a_pin_push_pull: assert property (@(posedge clock) disable iff (!reset_n) // R06
    cmp_mode_enable && ch1_cmp_ff[dgcc_pkg::BIT_CMP_PIN] && !ch1_cmp_ff[dgcc_pkg::BIT_CMP_OD] |=>
    ch1_output_pin_oe && (ch1_output_pin_o == cmp_result)) else $error("push-pull drive wrong");
  a_open_drain: assert property (@(posedge clock) disable iff (!reset_n) // R07
    ch1_cmp_ff[4] |=> !ch1_output_pin_o && (ch1_output_pin_oe == ($past(cmp_mode_enable && ch1_cmp_ff[3]) && !cmp_result)))
    else $error("open-drain drive wrong");
  a_window_mode: assert property (@(posedge clock) disable iff (!reset_n) // R09
    cmp_mode_enable && mode == dgcc_pkg::CMP_WINDOW && !ch1_cmp_ff[1] |=>
    cmp_result == ($past(cmp_above_lower) && !$past(cmp_above_upper))) else $error("window result wrong");
  a_write_readback: assert property (@(posedge clock) disable iff (!reset_n) // R11
    req.wr && !req.rd && req.addr == dgcc_pkg::ADDR_CH1_UPPER ##1 req.rd && !req.wr && req.addr == dgcc_pkg::ADDR_CH1_UPPER
    |=> rvalid && rdata == ($past(req.wdata, 2) & 16'hfff0)) else $error("upper bound readback wrong");
  // Mask chosen by the index that was read, since the six registers keep four different bit sets
  a_dont_care_zero: assert property (@(posedge clock) disable iff (!reset_n) // R12
    rvalid |-> (rdata & ~(
      ($past(req.addr) == dgcc_pkg::ADDR_CH2_LOWER || $past(req.addr) == dgcc_pkg::ADDR_CH1_UPPER) ?
        dgcc_pkg::MASK_BOUND :
      ($past(req.addr) == dgcc_pkg::ADDR_CH2_GAIN || $past(req.addr) == dgcc_pkg::ADDR_CH0_GAIN) ?
        dgcc_pkg::MASK_GAIN :
      ($past(req.addr) == dgcc_pkg::ADDR_CH1_GAIN_CMP) ? dgcc_pkg::MASK_GAIN_CMP :
      ($past(req.addr) == dgcc_pkg::ADDR_CH1_CMP_MODE) ? dgcc_pkg::MASK_CMP_MODE : 16'h0000)) == 16'h0000)
    else $error("don't-care bits read nonzero");
endmodule // dgcc_regs

/* dv/dgcc_host_model.sv */
// Purpose: Host controller model issuing single register accesses
// Assumes: Each task is entered just after a rising edge
// Notes: Released lines carry inverted values so stale data never looks valid
module dgcc_host_model (
  // Clock
  input wire logic clock,
  // Register port
  output dgcc_pkg::dgcc_req_t req,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // One write, then an idle edge so callers never drive twice in one step
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    @(posedge clock);
  endtask
  // One read; the answer pulse is awaited for a bounded number of cycles
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    ok = 1'b0;
    data = 16'h0000;
    req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 16'hffff};
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clock);
      ok = (rvalid === 1'b1);
    end
    if (ok)
      data = rdata;
    @(posedge clock);
  endtask
  // Write, then read the same index on the very next edge with no idle cycle
  task automatic write_read_reg(input logic [7:0] addr, input logic [15:0] value, output logic [15:0] data,
    output logic ok);
    ok = 1'b0;
    data = 16'h0000;
    req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: value};
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~value};
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 16'hffff};
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clock);
      ok = (rvalid === 1'b1);
    end
    if (ok)
      data = rdata;
    @(posedge clock);
  endtask
endmodule // dgcc_host_model

/* dv/test_dac_gain_comparator_config_regs.sv */
// Purpose: Self-checking bench for the converter configuration bank
// Assumes: Host model drives the register port, bench drives comparator levels
// Notes: Hysteresis cases run in order since they depend on held state
module test_dac_gain_comparator_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cmp_above_code, cmp_above_upper, cmp_above_lower, rvalid;
  logic ch0_gain_valid, ch1_gain_valid, current_range_valid, cmp_mode_enable;
  logic cmp_feedback_hiz_disable, cmp_mode_valid, cmp_result, ch1_output_pin_o, ch1_output_pin_oe;
  logic [9:0] ch1_lower_code, ch2_lower_code, ch1_upper_code;
  logic [2:0] ch0_ref_gain, ch1_ref_gain, current_range_field;
  logic [1:0] cmp_threshold_mode;
  logic [15:0] rdata;
  dgcc_pkg::dgcc_req_t req;
  int miscompares = 0;
  int checked = 0;
  logic [7:0] reg_addr [6] = '{8'h02, 8'h03, 8'h0f, 8'h13, 8'h15, 8'h17};
  logic [15:0] reg_mask [6] = '{16'hfff0, 16'h1c00, 16'h1c00, 16'hfff0, 16'h1c1f, 16'h0c00};
  dgcc_regs i_dgcc_regs (.clock, .reset_n, .req, .rdata, .rvalid, .cmp_above_code, .cmp_above_upper,
    .cmp_above_lower, .ch1_lower_code, .ch2_lower_code, .ch1_upper_code, .ch0_ref_gain, .ch0_gain_valid,
    .ch1_ref_gain, .ch1_gain_valid, .current_range_field, .current_range_valid, .cmp_mode_enable,
    .cmp_feedback_hiz_disable, .cmp_threshold_mode, .cmp_mode_valid, .cmp_result, .ch1_output_pin_o,
    .ch1_output_pin_oe);
  dgcc_host_model i_dgcc_host_model (.clock, .req, .rdata, .rvalid);
  // 25 MHz clock
  always #20 clock = ~clock;
  // Shared compare
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_dgcc_host_model.write_reg(a, d);
  endtask
  // Read and compare; a missing answer ends the run
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    logic ok;
    i_dgcc_host_model.read_reg(a, v, ok);
    if (!ok) begin
      miscompares++;
      results();
    end else begin
      check(v, exp);
    end
  endtask
  // Back-to-back write and read of one index
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
    logic [15:0] v;
    logic ok;
    i_dgcc_host_model.write_read_reg(a, d, v, ok);
    if (!ok) begin
      miscompares++;
      results();
    end else begin
      check(v, exp);
    end
  endtask
  task automatic reset_values();
    for (int i = 0; i < 6; i++)
      rd(reg_addr[i], 16'h0000);
    check(16'(ch0_gain_valid), 16'h0000);
    check(16'(current_range_valid), 16'h0001);
    check(16'(cmp_mode_valid), 16'h0001);
  endtask
  // All ones written: only documented fields stick, unmapped reads zero
  task automatic masks();
    for (int i = 0; i < 6; i++) begin
      wr(reg_addr[i], 16'hffff);
      rd(reg_addr[i], reg_mask[i]);
    end
    wr(8'h05, 16'hffff);
    rd(8'h05, 16'h0000);
    check(16'(ch1_upper_code), 16'h03ff);
    wr_rd(8'h13, 16'ha5a5, 16'ha5a0);
    wr(8'h02, 16'h8000);
    check(16'(ch2_lower_code), 16'h0200);
  endtask
  // Every code of the gain and mode fields
  task automatic gain_codes();
    for (int c = 0; c < 8; c++) begin
      wr(8'h0f, {3'h0, 3'(c), 10'h000});
      wr(8'h15, {3'h0, 3'(c), 10'h000});
      wr(8'h03, {3'h0, 3'(c), 10'h000});
      wr(8'h17, {4'h0, 2'(c), 10'h000});
      check(16'(ch0_ref_gain), 16'(c));
      check(16'(ch1_ref_gain), 16'(c));
      check(16'(current_range_field), 16'(c));
      check(16'(ch0_gain_valid), 16'(c >= 1 && c <= 5));
      check(16'(ch1_gain_valid), 16'(c >= 1 && c <= 5));
      check(16'(current_range_valid), 16'(c <= 1));
      check(16'(cmp_threshold_mode), 16'(c[1:0]));
      check(16'(cmp_mode_valid), 16'(c[1:0] != 2'b11));
    end
  endtask
  // Levels are {code, upper, lower}; pin data only judged while driven
  task automatic cmp_case(input logic [15:0] cfg, input logic [1:0] mode, input logic [2:0] ins,
    input logic eres, input logic eoe, input logic eo);
    wr(8'h15, cfg);
    wr(8'h17, {4'h0, mode, 10'h000});
    {cmp_above_code, cmp_above_upper, cmp_above_lower} <= ins;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(16'(cmp_result), 16'(eres));
    check(16'(cmp_mode_enable), 16'(cfg[0]));
    check(16'(cmp_feedback_hiz_disable), 16'(cfg[2]));
    check(16'(ch1_output_pin_oe), 16'(eoe));
    if (eoe)
      check(16'(ch1_output_pin_o), 16'(eo));
    @(posedge clock);
  endtask
  task automatic comparator();
    cmp_case(16'h0009, 2'b00, 3'b100, 1'b1, 1'b1, 1'b1);
    cmp_case(16'h000b, 2'b00, 3'b100, 1'b0, 1'b1, 1'b0);
    cmp_case(16'h0019, 2'b00, 3'b100, 1'b1, 1'b0, 1'b0);
    cmp_case(16'h0019, 2'b00, 3'b000, 1'b0, 1'b1, 1'b0);
    cmp_case(16'h0005, 2'b00, 3'b100, 1'b1, 1'b0, 1'b0);
    cmp_case(16'h0009, 2'b01, 3'b010, 1'b1, 1'b1, 1'b1);
    cmp_case(16'h0009, 2'b01, 3'b001, 1'b1, 1'b1, 1'b1);
    cmp_case(16'h0009, 2'b01, 3'b000, 1'b0, 1'b1, 1'b0);
    cmp_case(16'h0009, 2'b10, 3'b001, 1'b1, 1'b1, 1'b1);
    cmp_case(16'h0009, 2'b10, 3'b011, 1'b0, 1'b1, 1'b0);
    cmp_case(16'h0009, 2'b11, 3'b111, 1'b0, 1'b1, 1'b0);
    cmp_case(16'h0018, 2'b00, 3'b100, 1'b0, 1'b0, 1'b0);
  endtask
  // Main sequence
  initial begin
    {cmp_above_code, cmp_above_upper, cmp_above_lower} = 3'h0;
    ch1_lower_code = 10'h000;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    reset_values();
    masks();
    gain_codes();
    comparator();
    results();
  end
endmodule // test_dac_gain_comparator_config_regs
